// file: hdl/dewc_pkg.sv
// ==========================================================================
// shared constants for the data eeprom write controller
// ==========================================================================
package dewc_pkg;

    // ======================================================================
    // geometry
    // ======================================================================
    localparam int ADDR_W  = 7;   // 128 bytes of data eeprom
    localparam int ROW_W   = 2;   // four rows
    localparam int COL_W   = 5;   // 32 bytes per row
    localparam int ROW_LEN = 32;  // number of data latches
    localparam int MEM_LEN = 128;

    // ======================================================================
    // apb register offsets (byte addresses)
    // ======================================================================
    localparam logic [7:0] OFS_EECS  = 8'h00; // eeprom_control_status
    localparam logic [7:0] OFS_FCS   = 8'h04; // flash_control_status
    localparam logic [7:0] OFS_STAT  = 8'h08; // block state, read only
    localparam logic [7:0] OFS_PINC  = 8'h0c; // serial clock pin control

    // ======================================================================
    // field positions and reset values
    // ======================================================================
    localparam int EE_PGM_BIT    = 0;  // eeprom_program_bit
    localparam int EE_LAT_BIT    = 1;  // eeprom_latch_access_bit
    localparam int FL_PGM_BIT    = 0;  // flash_program_bit
    localparam int FL_LAT_BIT    = 1;  // flash_latch_bit
    localparam int FL_OPT_BIT    = 2;  // flash_option_select_bit
    localparam int PIN_OE_BIT    = 0;
    localparam int PIN_OUT_BIT   = 1;
    localparam logic [7:0] EECS_RST = 8'h00;
    localparam logic [2:0] FCS_RST  = 3'h0;
    localparam logic [1:0] PINC_RST = 2'h0;

    // ======================================================================
    // unlock keys and timing
    // ======================================================================
    localparam logic [7:0] UNLOCK_KEY1 = 8'h56;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hae;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int         PROG_CYCLES_DFLT = 1000; // self-timed cycle length
    localparam int         CNT_W = 16;

    typedef enum logic [1:0] {
        UNL_LOCKED,
        UNL_KEY1_SEEN,
        UNL_OPEN
    } dewc_unlock_t;

endpackage

// file: hdl/dewc_top.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module dewc_top
    import dewc_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
    // clock and reset
    input  wire logic              REF_CLK_I,
    input  wire logic              RST_I,
    // apb slave
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [7:0]        PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic [31:0]            PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    // eeprom memory port (cpu or programming tool)
    input  wire logic              MEM_SEL_I,
    input  wire logic              MEM_WE_I,
    input  wire logic              MEM_EXT_I,
    input  wire logic [ADDR_W-1:0] MEM_ADDR_I,
    input  wire logic [7:0]        MEM_WDATA_I,
    output logic [7:0]             MEM_RDATA_O,
    output logic                   MEM_RDATA_OE_O,
    // power modes
    input  wire logic              WFI_I,
    input  wire logic              HALT_I,
    output logic                   EE_WAIT_O,
    output logic                   EE_HALT_O,
    output logic                   EE_BUSY_O,
    // options and flash access
    input  wire logic              RP_OPT_I,
    input  wire logic              RP_REMOVE_I,
    input  wire logic              WEP_OPT_I,
    input  wire logic              IAP_MODE_I,
    input  wire logic              FLASH_SECTOR0_I,
    input  wire logic              FLASH_DONE_I,
    output logic                   FLASH_WRITE_OK_O,
    output logic                   FLASH_PGM_O,
    output logic                   FLASH_ERASE_ALL_O,
    // in-circuit programming entry and pin
    input  wire logic              ICP_ENTRY_I,
    input  wire logic              ICP_38_PULSE_I,
    output logic                   FORCE_RC_CLK_O,
    output logic                   OPT_BYTE_DIS_O,
    output logic                   SER_CLK_PIN_O,
    output logic                   SER_CLK_PIN_OE_O,
    output logic                   SER_CLK_PULLUP_O
);

    // ======================================================================
    // state
    // ======================================================================
    localparam logic [CNT_W-1:0] PROG_END = CNT_W'(PROG_CYCLES - 1);

    logic [7:0]       mem_q [MEM_LEN];
    logic [7:0]       lat_data_q [ROW_LEN];
    logic [ROW_LEN-1:0] lat_valid_q;
    logic [ROW_W-1:0] row_q;
    logic             ee_lat_q;
    logic             ee_pgm_q;
    logic [CNT_W-1:0] prog_cnt_q;
    logic             ee_wait_q;
    logic [2:0]       fcs_q;
    dewc_unlock_t     unlock_q;
    logic             wep_q;
    logic             icp_q;
    logic             force_rc_q;
    logic             opt_dis_q;
    logic [1:0]       pinc_q;
    logic [7:0]       rdata_q;
    logic             rdata_oe_q;
    logic [31:0]      prdata_q;
    logic             erase_q;

    // ======================================================================
    // decode
    // ======================================================================
    logic apb_wr;
    logic apb_setup_rd;
    logic mem_block;
    logic mem_rd;
    logic mem_wr;
    logic latch_wr;
    logic prog_done;
    logic halt_abort;
    logic lat_fall;
    logic eecs_wr;
    logic fcs_wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // apb write takes effect in the access phase, zero wait states
    assign apb_wr       = PSEL_I && PENABLE_I && PWRITE_I;
    assign apb_setup_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign eecs_wr      = apb_wr && hit(PADDR_I, OFS_EECS);
    assign fcs_wr       = apb_wr && hit(PADDR_I, OFS_FCS);

    // halted memory or a protected tool access sees nothing
    assign mem_block = HALT_I || (RP_OPT_I && MEM_EXT_I);
    assign mem_rd    = MEM_SEL_I && !MEM_WE_I && !mem_block;
    assign mem_wr    = MEM_SEL_I && MEM_WE_I && !mem_block;
    // writes while busy would corrupt the row being committed
    assign latch_wr  = mem_wr && ee_lat_q && !ee_pgm_q;
    assign halt_abort = HALT_I && ee_pgm_q;
    assign prog_done  = ee_pgm_q && !HALT_I && (prog_cnt_q == PROG_END);
    assign lat_fall   = eecs_wr && !ee_pgm_q && ee_lat_q
                        && !PWDATA_I[EE_LAT_BIT];

    // ======================================================================
    // eeprom control/status bits
    // ======================================================================
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            ee_lat_q <= EECS_RST[EE_LAT_BIT];
            ee_pgm_q <= EECS_RST[EE_PGM_BIT];
        end else if (prog_done || halt_abort) begin
            ee_lat_q <= 1'b0;
            ee_pgm_q <= 1'b0;
        end else if (eecs_wr && !ee_pgm_q) begin
            // software cannot clear anything while a cycle runs
            ee_lat_q <= PWDATA_I[EE_LAT_BIT];
            ee_pgm_q <= PWDATA_I[EE_PGM_BIT] && PWDATA_I[EE_LAT_BIT]
                        && ee_lat_q;
        end
    end

    // self-timed programming counter
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || !ee_pgm_q) begin
            prog_cnt_q <= '0;
        end else if (!HALT_I) begin
            prog_cnt_q <= prog_cnt_q + CNT_W'(1);
        end
    end

    // ======================================================================
    // data latches
    // ======================================================================
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || prog_done || halt_abort || lat_fall || erase_q) begin
            lat_valid_q <= '0;
        end else if (latch_wr) begin
            lat_valid_q[MEM_ADDR_I[COL_W-1:0]] <= 1'b1;
        end
    end

    // repeated writes over-program: the new byte ANDs into the old one
    always_ff @(posedge REF_CLK_I) begin
        if (latch_wr) begin
            if (lat_valid_q[MEM_ADDR_I[COL_W-1:0]]) begin
                lat_data_q[MEM_ADDR_I[COL_W-1:0]] <=
                    lat_data_q[MEM_ADDR_I[COL_W-1:0]] & MEM_WDATA_I;
            end else begin
                lat_data_q[MEM_ADDR_I[COL_W-1:0]] <= MEM_WDATA_I;
            end
        end
    end

    // last write decides the row; software keeps it constant
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            row_q <= '0;
        end else if (latch_wr) begin
            row_q <= MEM_ADDR_I[ADDR_W-1:COL_W];
        end
    end

    // ======================================================================
    // cell array: not reset, a reset mid-cycle leaves the row untouched
    // and therefore undefined from the user's point of view
    // ======================================================================
    always_ff @(posedge REF_CLK_I) begin
        if (erase_q) begin
            for (int i = 0; i < MEM_LEN; i++) begin
                mem_q[i] <= ERASED_BYTE;
            end
        end else if (prog_done && !RST_I) begin
            for (int i = 0; i < ROW_LEN; i++) begin
                if (lat_valid_q[i]) begin
                    mem_q[{row_q, COL_W'(i)}] <= lat_data_q[i];
                end
            end
        end
    end

    // ======================================================================
    // read path: registered, never sourced from the latches
    // ======================================================================
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            rdata_q    <= '0;
            rdata_oe_q <= 1'b0;
        end else if (mem_rd && !ee_lat_q) begin
            rdata_q    <= mem_q[MEM_ADDR_I];
            rdata_oe_q <= 1'b1;
        end else begin
            rdata_oe_q <= 1'b0;
        end
    end

    // ======================================================================
    // power modes
    // ======================================================================
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || !WFI_I) begin
            ee_wait_q <= 1'b0;
        end else if (!ee_pgm_q || prog_done) begin
            ee_wait_q <= 1'b1;
        end
    end

    // ======================================================================
    // read-out protection removal: one erase pulse for both memories
    // ======================================================================
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            erase_q <= 1'b0;
        end else begin
            erase_q <= RP_REMOVE_I;
        end
    end

    // write/erase strap caught after release and never dropped
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            wep_q <= 1'b0;
        end else begin
            wep_q <= wep_q || WEP_OPT_I;
        end
    end

    // ======================================================================
    // flash control register behind the two-key unlock
    // ======================================================================
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            unlock_q <= UNL_LOCKED;
        end else if (fcs_wr) begin
            case (unlock_q)
                UNL_LOCKED: begin
                    if (PWDATA_I[7:0] == UNLOCK_KEY1) begin
                        unlock_q <= UNL_KEY1_SEEN;
                    end
                end
                UNL_KEY1_SEEN: begin
                    if (PWDATA_I[7:0] == UNLOCK_KEY2) begin
                        unlock_q <= UNL_OPEN;
                    end else begin
                        unlock_q <= UNL_LOCKED;
                    end
                end
                default: begin
                    unlock_q <= UNL_OPEN;
                end
            endcase
        end
    end

    // software set of the program bit wins over the done clear
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            fcs_q <= FCS_RST;
        end else if (fcs_wr && unlock_q == UNL_OPEN) begin
            fcs_q <= PWDATA_I[2:0];
        end else if (FLASH_DONE_I) begin
            fcs_q[FL_PGM_BIT] <= 1'b0;
        end
    end

    // ======================================================================
    // in-circuit entry and serial clock pin
    // ======================================================================
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            icp_q      <= 1'b0;
            force_rc_q <= 1'b0;
            opt_dis_q  <= 1'b0;
        end else if (ICP_ENTRY_I) begin
            icp_q      <= 1'b1;
            force_rc_q <= ICP_38_PULSE_I;
            opt_dis_q  <= !ICP_38_PULSE_I;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            pinc_q <= PINC_RST;
        end else if (apb_wr && hit(PADDR_I, OFS_PINC)) begin
            pinc_q <= PWDATA_I[1:0];
        end
    end

    // ======================================================================
    // apb read data, captured in the setup phase
    // ======================================================================
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            prdata_q <= '0;
        end else if (apb_setup_rd) begin
            if (hit(PADDR_I, OFS_EECS)) begin
                prdata_q <= {30'h0, ee_lat_q, ee_pgm_q};
            end else if (hit(PADDR_I, OFS_FCS)) begin
                prdata_q <= {29'h0, fcs_q};
            end else if (hit(PADDR_I, OFS_STAT)) begin
                prdata_q <= {25'h0, opt_dis_q, force_rc_q, icp_q, wep_q,
                             RP_OPT_I, HALT_I, ee_wait_q};
            end else if (hit(PADDR_I, OFS_PINC)) begin
                prdata_q <= {30'h0, pinc_q};
            end else begin
                prdata_q <= '0;
            end
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    assign PRDATA_O   = prdata_q;
    assign PREADY_O   = 1'b1;
    assign PSLVERR_O  = PSEL_I && PENABLE_I && !(hit(PADDR_I, OFS_EECS)
                        || hit(PADDR_I, OFS_FCS) || hit(PADDR_I, OFS_STAT)
                        || hit(PADDR_I, OFS_PINC));
    assign MEM_RDATA_O    = rdata_q;
    assign MEM_RDATA_OE_O = rdata_oe_q;
    assign EE_WAIT_O  = ee_wait_q;
    assign EE_HALT_O  = HALT_I;
    assign EE_BUSY_O  = ee_pgm_q;
    // sector 0 stays intact under application programming
    assign FLASH_WRITE_OK_O = !wep_q
                              && !(IAP_MODE_I && FLASH_SECTOR0_I)
                              && !(RP_OPT_I && icp_q);
    assign FLASH_PGM_O       = fcs_q[FL_PGM_BIT] && FLASH_WRITE_OK_O;
    assign FLASH_ERASE_ALL_O = erase_q;
    assign FORCE_RC_CLK_O    = force_rc_q;
    assign OPT_BYTE_DIS_O    = opt_dis_q;
    assign SER_CLK_PIN_O     = pinc_q[PIN_OUT_BIT];
    assign SER_CLK_PIN_OE_O  = pinc_q[PIN_OE_BIT];
    assign SER_CLK_PULLUP_O  = !pinc_q[PIN_OE_BIT];

    // ======================================================================
    // checks
    // ======================================================================
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    logic [7:0] rd_ref;
    logic [7:0] and_ref;
    assign rd_ref  = mem_q[MEM_ADDR_I];
    assign and_ref = lat_data_q[MEM_ADDR_I[COL_W-1:0]] & MEM_WDATA_I;

    chk_done_clears_bits: assert property (
        prog_done |=> !ee_lat_q && !ee_pgm_q)
        else $error("cycle end left control bits set");
    chk_read_as_rom: assert property (
        mem_rd && !ee_lat_q |=> MEM_RDATA_OE_O
                                && MEM_RDATA_O == $past(rd_ref))
        else $error("read mode did not return cell data");
    chk_read_undriven: assert property (
        MEM_SEL_I && !MEM_WE_I && ee_lat_q |=> !MEM_RDATA_OE_O)
        else $error("bus driven while latch access set");
    chk_write_ignored: assert property (
        mem_wr && !ee_lat_q && !ee_pgm_q && !lat_fall && !erase_q
        |=> $stable(lat_valid_q))
        else $error("write captured in read mode");
    chk_latch_and_merge: assert property (
        latch_wr && lat_valid_q[MEM_ADDR_I[COL_W-1:0]]
        |=> lat_data_q[$past(MEM_ADDR_I[COL_W-1:0])] == $past(and_ref))
        else $error("repeated latch write did not AND");
    chk_pgm_held_busy: assert property (
        ee_pgm_q && !prog_done && !halt_abort |=> ee_pgm_q)
        else $error("program bit dropped while busy");
    chk_lat_clear_refused: assert property (
        eecs_wr && ee_pgm_q && !prog_done && !halt_abort |=> ee_lat_q)
        else $error("latch access cleared during a cycle");
    chk_halt_abandons: assert property (
        HALT_I && ee_pgm_q |=> !ee_pgm_q && lat_valid_q == '0)
        else $error("halt did not abandon the cycle");
    chk_wait_when_idle: assert property (
        WFI_I && !ee_pgm_q |=> ee_wait_q || !WFI_I)
        else $error("idle eeprom did not enter wait");
    chk_wait_not_busy: assert property (
        ee_wait_q |-> !ee_pgm_q)
        else $error("wait entered during programming");
    chk_key_restart: assert property (
        fcs_wr && unlock_q == UNL_KEY1_SEEN && PWDATA_I[7:0] != UNLOCK_KEY2
        |=> unlock_q == UNL_LOCKED)
        else $error("wrong key did not restart unlock");
    chk_sector0_refused: assert property (
        IAP_MODE_I && FLASH_SECTOR0_I |-> !FLASH_WRITE_OK_O && !FLASH_PGM_O)
        else $error("sector 0 open to application programming");
    chk_wep_permanent: assert property (
        wep_q |=> wep_q && !FLASH_WRITE_OK_O)
        else $error("write protection lost");

    cov_prog_done: cover property (prog_done);
    cov_latch_merge: cover property (
        latch_wr && lat_valid_q[MEM_ADDR_I[COL_W-1:0]]);
    cov_unlocked: cover property (
        unlock_q == UNL_KEY1_SEEN ##1 unlock_q == UNL_OPEN);
    cov_halt_abort: cover property (halt_abort);

endmodule
`default_nettype wire

// file: sim/dewc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ===================================
// cpu side of the eeprom memory port
// ===================================
module dewc_mem_model
    import dewc_pkg::*;
(
    // bus
    input  wire logic              clk_i,
    output logic                   sel_o,
    output logic                   we_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [7:0]             wdata_o
);
    // idle bus shows inverted address and data, we keeps its value, so stale data never looks valid
    initial {sel_o, we_o, addr_o, wdata_o} = '0;
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [7:0] d);
        @(posedge clk_i);
        {sel_o, we_o, addr_o, wdata_o} <= {1'b1, w, a, d};
        @(posedge clk_i);
        {sel_o, addr_o, wdata_o} <= {1'b0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// file: sim/data_eeprom_write_controller_test.sv
`timescale 1ns/1ns
`default_nettype none
module data_eeprom_write_controller_test;
    import dewc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, wait_for_interrupt_instr = 0, err;
    logic [7:0] paddr = '0, mrd;
    logic [31:0] pwd = '0, rd, prd;
    logic [4:0] misc = '0;
    logic halt = 0, rrm = 0, icpe = 0;
    logic ehalt, wok, erall, frc, odis, spin, soe, spu;
    logic sel, we, rdy, slverr, moe, ewait, busy;
    logic [ADDR_W-1:0] ma;
    logic [7:0] md, img [ROW_LEN], expq [$];
    int miscompares = 0, checks = 0, cyc = 0;
    always #5 clk = ~clk;
    dewc_mem_model mem (.clk_i(clk), .sel_o(sel), .we_o(we), .addr_o(ma),
        .wdata_o(md));
    dewc_top #(.PROG_CYCLES(16)) dut (.REF_CLK_I(clk), .RST_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(slverr),
        .MEM_SEL_I(sel), .MEM_WE_I(we), .MEM_EXT_I(1'b0), .MEM_ADDR_I(ma),
        .MEM_WDATA_I(md), .MEM_RDATA_O(mrd), .MEM_RDATA_OE_O(moe),
        .WFI_I(wait_for_interrupt_instr), .HALT_I(halt), .EE_WAIT_O(ewait), .EE_HALT_O(ehalt),
        .EE_BUSY_O(busy), .RP_OPT_I(1'b0), .RP_REMOVE_I(rrm),
        .WEP_OPT_I(misc[0]), .IAP_MODE_I(misc[1]), .FLASH_SECTOR0_I(misc[2]),
        .FLASH_DONE_I(misc[3]), .FLASH_WRITE_OK_O(wok), .FLASH_PGM_O(),
        .FLASH_ERASE_ALL_O(erall), .ICP_ENTRY_I(icpe),
        .ICP_38_PULSE_I(misc[4]), .FORCE_RC_CLK_O(frc),
        .OPT_BYTE_DIS_O(odis), .SER_CLK_PIN_O(spin),
        .SER_CLK_PIN_OE_O(soe), .SER_CLK_PULLUP_O(spu));
    // ==========================
    // checking and closing
    // ==========================
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // apb master: request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, paddr, pwd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        err = slverr;
        {psel, pen} <= 2'b00;
    endtask
    // read monitor: an unexpected driven read forces a mismatch
    always @(posedge clk) begin
        if (moe === 1'b1) begin
            if (expq.size() == 0) chk(32'hffffffff, {24'h0, mrd});
            else chk({24'h0, expq.pop_front()}, {24'h0, mrd});
        end
    end
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(84621));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        misc <= 5'($urandom);
        apb(0, OFS_FCS, 0); chk({24'h0, 8'h00}, rd);
        apb(0, 8'h40, 0); chk(1, err);
        apb(1, OFS_FCS, 32'h2); apb(0, OFS_FCS, 0); chk(0, rd);
        apb(1, OFS_FCS, {24'h0, UNLOCK_KEY1});
        apb(1, OFS_FCS, {24'h0, UNLOCK_KEY2});
        apb(1, OFS_FCS, 32'h2); apb(0, OFS_FCS, 0); chk(2, rd);
        $display("test registers done");
        apb(1, OFS_EECS, 32'h2);
        foreach (img[i]) img[i] = 8'($urandom);
        foreach (img[i]) mem.acc(1, {2'd1, 5'(i)}, img[i]);
        mem.acc(1, {2'd1, 5'd3}, 8'h5a);
        img[3] &= 8'h5a;
        mem.acc(0, {2'd1, 5'd0}, 0);
        apb(1, OFS_EECS, 32'h3);
        wait_for_interrupt_instr <= 1'b1;
        #1 chk(1, busy);
        chk(0, ewait);
        while (busy === 1'b1) @(posedge clk);
        wait_for_interrupt_instr <= 1'b0;
        #1 chk(1, ewait);
        apb(0, OFS_EECS, 0); chk(0, rd);
        mem.acc(1, {2'd1, 5'd7}, 8'h00);
        foreach (img[i]) expq.push_back(img[i]);
        foreach (img[i]) mem.acc(0, {2'd1, 5'(i)}, 0);
        // halt abandons a started cycle, the row keeps its old bytes
        apb(1, OFS_EECS, 32'h2);
        mem.acc(1, {2'd1, 5'd0}, ~img[0]);
        apb(1, OFS_EECS, 32'h3);
        apb(1, OFS_EECS, 32'h0); apb(0, OFS_EECS, 0); chk(3, rd);
        halt <= 1'b1;
        #1 chk(1, ehalt);
        @(posedge clk);
        halt <= 1'b0;
        #1 chk(0, busy);
        expq.push_back(img[0]);
        mem.acc(0, {2'd1, 5'd0}, 0);
        // protection removal wipes the whole array to the erased value
        rrm <= 1'b1;
        @(posedge clk);
        rrm <= 1'b0;
        #1 chk(1, erall);
        expq.push_back(ERASED_BYTE);
        mem.acc(0, {2'd1, 5'd5}, 0);
        repeat (3) @(posedge clk);
        chk(0, 32'(expq.size()));
        $display("test eeprom row done");
        // pin driven as output, then a mid-run reset must release it
        apb(1, OFS_PINC, 32'h3);
        rst <= 1'b1;
        #1 chk(3'b110, {spin, soe, spu});
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk(3'b001, {spin, soe, spu});
        @(posedge clk);
        icpe <= 1'b1;
        @(posedge clk);
        icpe <= 1'b0;
        #1 chk({misc[4], !misc[4]}, {frc, odis});
        chk(!misc[0] && !(misc[1] && misc[2]), wok);
        $display("test pins and entry done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
